//--- hw/dps_pkg.sv
// Package for the dual-port SRAM port host controller.
// Assumes a 125 MHz system clock and one port of an 8-bit dual-port SRAM.
package dps_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  // ==========================================================
  // Timing, in ns as specified, and derived cycle counts
  localparam int CLK_NS = 8;
  localparam int T_RC_NS = 25;
  localparam int T_AA_NS = 25;
  localparam int T_AOE_NS = 15;
  localparam int T_WC_NS = 25;
  localparam int T_EW_NS = 20;
  localparam int T_AW_NS = 20;
  localparam int T_WP_NS = 20;
  localparam int T_WZ_NS = 15;
  localparam int T_DW_NS = 15;
  localparam int T_SOP_NS = 15;
  localparam int T_SAA_NS = 35;
  localparam int T_SWRD_NS = 5;
  localparam int T_SPS_NS = 5;
  // Rounds a least time up to whole cycles, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int WP_MIN = (T_WP_NS > T_EW_NS) ? T_WP_NS : T_EW_NS;
  localparam int WP_OE_NS = ((T_WZ_NS + T_DW_NS) > WP_MIN) ?
    (T_WZ_NS + T_DW_NS) : WP_MIN;
  localparam logic [CNT_W-1:0] RD_CYC = CNT_W'(cyc_up(T_RC_NS));
  localparam logic [CNT_W-1:0] OE_CYC = CNT_W'(cyc_up(T_AOE_NS));
  localparam logic [CNT_W-1:0] WR_CYC = CNT_W'(cyc_up(WP_OE_NS));
  localparam logic [CNT_W-1:0] WC_CYC = CNT_W'(cyc_up(T_WC_NS));
  localparam logic [CNT_W-1:0] SRD_CYC = CNT_W'(cyc_up(T_SAA_NS));
  localparam logic [CNT_W-1:0] SWR_CYC =
    CNT_W'(cyc_up((T_SOP_NS > T_EW_NS) ? T_SOP_NS : T_EW_NS));
  localparam logic [CNT_W-1:0] SWRD_CYC =
    CNT_W'(cyc_up((T_SWRD_NS > T_SPS_NS) ? T_SWRD_NS : T_SPS_NS));
  // ==========================================================
  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  // ==========================================================
  // Access kinds and sequencer states
  typedef enum logic [1:0] {
    DPS_RD, DPS_WR, DPS_SRD, DPS_SWR
  } dps_op_t;
  typedef enum {
    DPS_IDLE, DPS_SETUP, DPS_STROBE, DPS_RECOV, DPS_GAP
  } dps_state_t;
endpackage

//--- hw/dps_cnt.sv
// Down counter for access phases.
// Assumes load and value come from the sequencer on the same clock.
`timescale 1ns/1ns
`default_nettype none
module dps_cnt
  import dps_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Control
  input wire logic load_i,
  input wire logic [CNT_W-1:0] value_i,
  // Status
  output logic done_o
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // ==========================================================
  // Next count
  always_comb begin
    if (load_i) begin
      cnt_nxt = value_i - 4'h1;
    end else if (cnt_r != CNT_RST) begin
      cnt_nxt = cnt_r - 4'h1;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  // Count register
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_o = (cnt_r == CNT_RST) && !load_i;
endmodule
`default_nettype wire

//--- hw/dps_host.sv
// Host controller driving one port of an 8-bit dual-port SRAM.
// Assumes the SRAM pins are wired to the ports, data through a tristate
// resolved outside from data_oe_o.
// How it works
// R1: Array access uses chip select low, flag select high; semaphore reversed.
// R2: Selection held steady for the whole write, at least 20 ns.
// R3: Write happens while select and write strobe low; ends at first rise.
// R4: Address changes only while the write strobe is high.
// R5: Device keeps outputs off when select falls with or after strobe.
// R6: Strobe lasts max of write pulse and turn-off plus data setup.
// R7: Successive writes start at least 25 ns apart.
// R8: Address valid 20 ns before write end, set up before strobe.
// R9: Data valid 15 ns before write end, held past strobe end.
// R10: Recovery after strobe rise may be zero ns.
// R11: Read cycles last at least 25 ns; data sampled after access.
// R12: Read data taken after the slowest access delay.
// R13: Conflict delay only for opposite write; not tracked here.
// R14: Device holds old data 3 ns after address change.
// R15: Semaphore update pulse at least 15 ns; read waits 35 ns.
// R16: At least 5 ns between semaphore write and its read.
// R17: Semaphore requests spaced by a 5 ns contention window.
// R18: Chip select high during semaphore access; all bits carry the flag.
// R19: Missed window still grants one port; outcome unknown.
// R20: All intervals are whole clock cycles rounded up.
`timescale 1ns/1ns
`default_nettype none
module dps_host
  import dps_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // User request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [1:0] req_op_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  // User answer
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_rdata_o,
  // SRAM port pins
  output logic [ADDR_W-1:0] addr_o,
  output logic chip_select_n_o,
  output logic flag_select_n_o,
  output logic read_write_n_o,
  output logic output_drive_n_o,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [DATA_W-1:0] data_i
);
  dps_state_t st_r, st_nxt;
  dps_op_t op_r, op_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic rsp_r, rsp_nxt;
  logic cs_n_r, cs_n_nxt;
  logic fs_n_r, fs_n_nxt;
  logic rw_n_r, rw_n_nxt;
  logic oe_n_r, oe_n_nxt;
  logic doe_r, doe_nxt;
  logic [DATA_W-1:0] din_s1_r, din_s2_r;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_val;
  logic cnt_done;

  // Strobe length for each access kind
  function automatic logic [CNT_W-1:0] op_len(input dps_op_t op);
    case (op)
      DPS_RD: op_len = RD_CYC; // [R11] [R12] [R20]
      DPS_WR: op_len = WR_CYC; // [R6] [R2] [R8] [R9]
      DPS_SRD: op_len = SRD_CYC; // [R15]
      DPS_SWR: op_len = SWR_CYC; // [R15] [R2]
      default: op_len = RD_CYC;
    endcase
  endfunction

  function automatic logic is_write(input dps_op_t op);
    is_write = (op == DPS_WR) || (op == DPS_SWR);
  endfunction

  // ==========================================================
  // Phase counter
  dps_cnt dps_cnt_inst (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .load_i(cnt_load),
    .value_i(cnt_val),
    .done_o(cnt_done)
  );

  // ==========================================================
  // Read data synchroniser, two stages before use
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      din_s1_r <= DATA_RST;
      din_s2_r <= DATA_RST;
    end else begin
      din_s1_r <= data_i;
      din_s2_r <= din_s1_r;
    end
  end

  // ==========================================================
  // Sequencer next state
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    rsp_nxt = 1'b0;
    cs_n_nxt = cs_n_r;
    fs_n_nxt = fs_n_r;
    rw_n_nxt = rw_n_r;
    oe_n_nxt = oe_n_r;
    doe_nxt = doe_r;
    cnt_load = 1'b0;
    cnt_val = CNT_RST;
    case (st_r)
      DPS_IDLE: begin
        if (req_valid_i) begin
          // Address moves only with strobe and selects high
          op_nxt = dps_op_t'(req_op_i);
          addr_nxt = req_addr_i; // [R4] [R8]
          wdata_nxt = req_wdata_i;
          st_nxt = DPS_SETUP;
        end
      end
      DPS_SETUP: begin
        // Select and strobe fall together; outputs stay off on writes, turn on with select on reads
        cs_n_nxt = (op_r == DPS_RD) || (op_r == DPS_WR) ?
          1'b0 : 1'b1; // [R1] [R18]
        fs_n_nxt = (op_r == DPS_SRD) || (op_r == DPS_SWR) ?
          1'b0 : 1'b1; // [R1]
        rw_n_nxt = !is_write(op_r); // [R3] [R5]
        oe_n_nxt = is_write(op_r);
        doe_nxt = is_write(op_r); // [R9]
        cnt_load = 1'b1;
        cnt_val = op_len(op_r);
        st_nxt = DPS_STROBE;
      end
      DPS_STROBE: begin
        if (cnt_done) begin
          // Write ends on strobe rise; data still driven
          rw_n_nxt = 1'b1; // [R3] [R10]
          cs_n_nxt = 1'b1;
          fs_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          st_nxt = DPS_RECOV;
        end
      end
      DPS_RECOV: begin
        // Data held one cycle past strobe end
        doe_nxt = 1'b0; // [R9]
        cnt_load = 1'b1;
        cnt_val = (op_r == DPS_SWR) ? SWRD_CYC : WC_CYC; // [R7] [R16] [R17]
        st_nxt = DPS_GAP;
      end
      DPS_GAP: begin
        if (is_write(op_r) && !cnt_done) begin
          st_nxt = DPS_GAP; // [R7] [R16]
        end else begin
          if (!is_write(op_r)) begin
            // Second sync stage now holds the bus seen at the strobe's
            // last edge, the first edge past the worst-case access time;
            // relies on the device holding its data just after the rise
            rdata_nxt = din_s2_r; // [R12] [R14] [R18] [R20]
          end
          rsp_nxt = 1'b1; // [R11]
          st_nxt = DPS_IDLE;
        end
      end
      default: st_nxt = DPS_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= DPS_IDLE;
      op_r <= DPS_RD;
      addr_r <= ADDR_RST;
      wdata_r <= DATA_RST;
      rdata_r <= DATA_RST;
      rsp_r <= 1'b0;
      cs_n_r <= 1'b1;
      fs_n_r <= 1'b1;
      rw_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      doe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
      cs_n_r <= cs_n_nxt;
      fs_n_r <= fs_n_nxt;
      rw_n_r <= rw_n_nxt;
      oe_n_r <= oe_n_nxt;
      doe_r <= doe_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign req_ready_o = (st_r == DPS_IDLE);
  assign rsp_valid_o = rsp_r;
  assign rsp_rdata_o = rdata_r;
  assign addr_o = addr_r;
  assign chip_select_n_o = cs_n_r;
  assign flag_select_n_o = fs_n_r;
  assign read_write_n_o = rw_n_r;
  assign output_drive_n_o = oe_n_r;
  assign data_o = wdata_r;
  assign data_oe_o = doe_r;
endmodule
`default_nettype wire

//--- dv/dps_host_asserts.sv
// Checker for the SRAM port host controller pin sequencing.
// Assumes binding to dps_host and the dps_pkg cycle counts.
`timescale 1ns/1ns
`default_nettype none
module dps_host_asserts
  import dps_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Watched outputs
  input wire logic rsp_valid_o,
  input wire logic [ADDR_W-1:0] addr_o,
  input wire logic chip_select_n_o,
  input wire logic flag_select_n_o,
  input wire logic read_write_n_o,
  input wire logic output_drive_n_o,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic data_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================================
  // Selection and write properties
  property p_sel_excl; !(!chip_select_n_o && !flag_select_n_o); endproperty
  a_sel_excl: assert property (p_sel_excl)
    else $error("both selects low");
  property p_addr_move;
    $changed(addr_o) |-> $past(chip_select_n_o && flag_select_n_o) &&
      read_write_n_o;
  endproperty
  a_addr_move: assert property (p_addr_move) else $error("addr moved");
  property p_sel_with_strobe;
    $fell(read_write_n_o) |-> $fell(chip_select_n_o) || $fell(flag_select_n_o);
  endproperty
  a_sel_with_strobe: assert property (p_sel_with_strobe)
    else $error("sel");
  property p_wr_hold;
    !read_write_n_o && $past(!read_write_n_o) |->
      $stable({data_o, addr_o, chip_select_n_o, flag_select_n_o});
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write moved");
  property p_arr_wr;
    $fell(read_write_n_o) && !chip_select_n_o |->
      (!read_write_n_o && !chip_select_n_o && data_oe_o)[*4]
      ##1 (read_write_n_o && chip_select_n_o && data_oe_o) ##1 !data_oe_o;
  endproperty
  a_arr_wr: assert property (p_arr_wr)
    else $error("array write");
  property p_sem_wr;
    $fell(read_write_n_o) && !flag_select_n_o |->
      (!read_write_n_o && !flag_select_n_o)[*3]
      ##1 (read_write_n_o && flag_select_n_o) ##1 flag_select_n_o;
  endproperty
  a_sem_wr: assert property (p_sem_wr) else $error("sem write");
  property p_wr_gap; $rose(read_write_n_o) |-> read_write_n_o[*4]; endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("write gap");
  property p_no_fight; !(data_oe_o && !output_drive_n_o); endproperty
  a_no_fight: assert property (p_no_fight) else $error("bus fight");
  // ==========================================================
  // Read properties
  property p_arr_rd;
    $fell(output_drive_n_o) && !chip_select_n_o |->
      (!output_drive_n_o && !chip_select_n_o)[*4]
      ##1 (output_drive_n_o && chip_select_n_o) ##2 rsp_valid_o;
  endproperty
  a_arr_rd: assert property (p_arr_rd) else $error("array read");
  property p_sem_rd;
    $fell(output_drive_n_o) && !flag_select_n_o |->
      (!output_drive_n_o && !flag_select_n_o && chip_select_n_o)[*5]
      ##1 (output_drive_n_o && flag_select_n_o) ##2 rsp_valid_o;
  endproperty
  a_sem_rd: assert property (p_sem_rd) else $error("sem read");
  // Main scenarios
  c_rd: cover property ($fell(output_drive_n_o) && !chip_select_n_o);
  c_wr: cover property ($fell(read_write_n_o) && !chip_select_n_o);
  c_swr: cover property ($fell(read_write_n_o) && !flag_select_n_o);
endmodule
bind dps_host dps_host_asserts dps_host_asserts_inst (.clock_i(clock_i),
  .nrst_i(nrst_i), .rsp_valid_o(rsp_valid_o), .addr_o(addr_o),
  .chip_select_n_o(chip_select_n_o), .flag_select_n_o(flag_select_n_o),
  .read_write_n_o(read_write_n_o), .output_drive_n_o(output_drive_n_o),
  .data_o(data_o), .data_oe_o(data_oe_o));
`default_nettype wire

//--- dv/dps_sram_model.sv
// Behavioural model of one port of the 8-bit dual-port SRAM.
// Assumes the bench resolves the data bus from both drivers.
`timescale 1ns/1ns
`default_nettype none
module dps_sram_model
  import dps_pkg::*;
(
  // Port pins
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic chip_select_n_i,
  input wire logic flag_select_n_i,
  input wire logic read_write_n_i,
  input wire logic output_drive_n_i,
  // Data bus
  input wire logic [DATA_W-1:0] bus_i,
  output logic [DATA_W-1:0] q_o
);
  logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];
  logic [7:0] flag_r = 8'hff;
  realtime t_a = 0;
  realtime t_oe = 0;
  logic wr_arr;
  logic wr_sem;
  logic rd_on;
  logic [DATA_W-1:0] q_r = 8'h00;
  // Write windows and read drive
  assign wr_arr = !chip_select_n_i && !read_write_n_i;
  assign wr_sem = !flag_select_n_i && !read_write_n_i;
  assign rd_on = (!chip_select_n_i || !flag_select_n_i) && read_write_n_i &&
    !output_drive_n_i;
  assign q_o = q_r;
  // Write lands at first rise; single port always wins its flag
  always @(negedge wr_arr) mem[addr_i] = bus_i;
  always @(negedge wr_sem) flag_r[addr_i[2:0]] = bus_i[0];
  always @(addr_i or chip_select_n_i or flag_select_n_i) t_a = $realtime;
  always @(negedge output_drive_n_i) t_oe = $realtime;
  // Released or unsettled bus toggles; no opposite port, no conflict delay
  always #1 begin
    if (!rd_on) q_r = ~q_r;
    else if ($realtime - t_a < 3) q_r = q_r;
    else if ($realtime - t_a < (flag_select_n_i ? T_AA_NS : T_SAA_NS) ||
      $realtime - t_oe < T_AOE_NS) q_r = ~q_r;
    else if (flag_select_n_i) q_r = mem[addr_i];
    else q_r = {8{flag_r[addr_i[2:0]]}};
  end
endmodule
`default_nettype wire

//--- dv/tb_dual_port_sram_async_access.sv
// Bench for the SRAM port host controller against the port model.
// Assumes dps_host, dps_sram_model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch at %0t: %h %h", $time, (a), (b)); end end
module tb_dual_port_sram_async_access;
  import dps_pkg::*;
  logic clock_i = 0;
  logic nrst_i = 0;
  logic req_valid_i = 0;
  logic [1:0] req_op_i = 2'h0;
  logic [ADDR_W-1:0] req_addr_i = 15'h0000;
  logic [DATA_W-1:0] req_wdata_i = 8'h00;
  logic req_ready_o, rsp_valid_o, chip_select_n_o, flag_select_n_o;
  logic read_write_n_o, output_drive_n_o, data_oe_o;
  logic [DATA_W-1:0] rsp_rdata_o, data_o, sram_q;
  logic [ADDR_W-1:0] addr_o;
  wire logic [DATA_W-1:0] bus;
  int err_count = 0;
  int checks = 0;
  // Clock and bus resolution
  always #4 clock_i = ~clock_i;
  assign bus = data_oe_o ? data_o : sram_q;
  dps_host dps_host_inst (.clock_i(clock_i), .nrst_i(nrst_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .addr_o(addr_o),
    .chip_select_n_o(chip_select_n_o), .flag_select_n_o(flag_select_n_o),
    .read_write_n_o(read_write_n_o), .output_drive_n_o(output_drive_n_o),
    .data_o(data_o), .data_oe_o(data_oe_o), .data_i(bus));
  dps_sram_model dps_sram_model_inst (.addr_i(addr_o),
    .chip_select_n_i(chip_select_n_o), .flag_select_n_i(flag_select_n_o),
    .read_write_n_i(read_write_n_o), .output_drive_n_i(output_drive_n_o),
    .bus_i(bus), .q_o(sram_q));
  // Verdict and end of run
  task automatic stop_test;
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One request, waits for its answer and counts the cycles
  task automatic xfer(input logic [1:0] op, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output int n);
    int i;
    i = 0;
    @(posedge clock_i);
    #1;
    req_valid_i = 1;
    req_op_i = op;
    req_addr_i = a;
    req_wdata_i = d;
    while (req_ready_o !== 1'b1 && i < 30) begin
      @(posedge clock_i);
      #1;
      i++;
    end
    // Taken at this edge; lowered just after it
    @(posedge clock_i);
    #1;
    req_valid_i = 0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 40) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (i == 30 || n == 40) begin
      err_count++;
      stop_test();
    end
    q = rsp_rdata_o;
  endtask
  // Idle pin levels
  task automatic t_idle;
    `CHK({chip_select_n_o, flag_select_n_o, read_write_n_o, output_drive_n_o,
      data_oe_o, rsp_valid_o, req_ready_o}, 7'h79)
  endtask
  // Array writes at both address ends, read back
  task automatic t_array;
    logic [7:0] q;
    int n;
    xfer(DPS_WR, 15'h7fff, 8'ha5, q, n);
    `CHK(n, 2 + int'(WR_CYC) + int'(WC_CYC))
    xfer(DPS_WR, 15'h0000, 8'h5a, q, n);
    `CHK(n, 2 + int'(WR_CYC) + int'(WC_CYC))
    xfer(DPS_RD, 15'h7fff, 8'h00, q, n);
    `CHK(q, 8'ha5)
    `CHK(n, 3 + int'(RD_CYC))
    xfer(DPS_RD, 15'h0000, 8'hff, q, n);
    `CHK(q, 8'h5a)
  endtask
  // Semaphore write then read, both flag values
  task automatic t_sem;
    logic [7:0] q;
    int n;
    xfer(DPS_WR, 15'h0003, 8'h3c, q, n);
    xfer(DPS_SWR, 15'h0003, 8'h00, q, n);
    `CHK(n, 2 + int'(SWR_CYC) + int'(SWRD_CYC))
    xfer(DPS_SRD, 15'h0003, 8'h55, q, n);
    `CHK(q, 8'h00)
    `CHK(n, 3 + int'(SRD_CYC))
    xfer(DPS_SWR, 15'h0003, 8'hff, q, n);
    xfer(DPS_SRD, 15'h0003, 8'h00, q, n);
    `CHK(q, 8'hff)
    xfer(DPS_RD, 15'h0003, 8'h00, q, n);
    `CHK(q, 8'h3c)
    xfer(DPS_RD, 15'h7fff, 8'h00, q, n);
    `CHK(q, 8'ha5)
  endtask
  // Reset in mid-write, then old data still readable
  task automatic t_mid_reset;
    logic [7:0] q;
    int n;
    repeat (2) @(posedge clock_i);
    #1 req_valid_i = 1; req_op_i = DPS_WR; req_addr_i = 15'h1234;
    @(posedge clock_i); #1 req_valid_i = 0;
    repeat (3) @(posedge clock_i);
    #1 nrst_i = 0;
    #1 t_idle();
    @(posedge clock_i); #1 nrst_i = 1;
    xfer(DPS_RD, 15'h7fff, 8'h00, q, n);
    `CHK(q, 8'ha5)
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clock_i);
    #1 t_idle();
    repeat (5) @(posedge clock_i);
    #1 nrst_i = 1;
    t_array();
    t_sem();
    t_mid_reset();
    stop_test();
  end
endmodule
`default_nettype wire
